// *** src/uhmu_pkg.sv ***
// Opcodes, carriers and timing of the upper-half multiply unit.
`default_nettype none
package uhmu_pkg;
	localparam logic [4:0] OP_MINU   = 5'h13;
	localparam logic [4:0] OP_MULH   = 5'h17;
	localparam logic [4:0] OP_MULHH  = 5'h1D;
	localparam logic [4:0] OP_MULHHS = 5'h14;
	localparam logic [4:0] OP_MULHHU = 5'h1E;
	localparam logic [4:0] OP_MULHS  = 5'h1F;
	localparam logic [4:0] OP_MULHU  = 5'h18;
	localparam logic [5:0] LINK_REG  = 6'h3F;
	localparam int         HALF_SHIFT = 16;
	localparam int         MUL_LATENCY = 2;
	localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
	localparam logic [5:0]  DEST_RESET   = 6'h00;

	typedef struct packed {
		logic        valid;
		logic [4:0]  opcode;
		logic        imm_form;
		logic [5:0]  dest;
		logic [31:0] first_source_reg;
		logic [31:0] second_source_reg;
		logic [31:0] immediate_operand;
	} uhmu_issue_type;

	typedef struct packed {
		logic        valid;
		logic [5:0]  dest;
		logic [31:0] data;
	} uhmu_wb_type;
endpackage
`default_nettype wire

// *** src/uhmu_unit.sv ***
// Execution datapath for unsigned minimum and upper-half-word multiplies.
`default_nettype none
module uhmu_unit
(
	// Clock and reset.
	input  wire logic                     clock,
	input  wire logic                     rstn,
	// Issue side.
	input  wire uhmu_pkg::uhmu_issue_type issue,
	// Results and status.
	output uhmu_pkg::uhmu_wb_type         alu_result,
	output uhmu_pkg::uhmu_wb_type         mul_result,
	output logic                          illegal_dest
);

	////////////////////////////////////////////////////////////////////////
	// Operation decode and datapath.

	function automatic logic is_mul(input logic [4:0] op);
		is_mul = (op == uhmu_pkg::OP_MULH) || (op == uhmu_pkg::OP_MULHH) ||
			(op == uhmu_pkg::OP_MULHHS) || (op == uhmu_pkg::OP_MULHHU) ||
			(op == uhmu_pkg::OP_MULHS) || (op == uhmu_pkg::OP_MULHU);
	endfunction

	logic [31:0] op_a;
	logic [31:0] op_b;
	logic [31:0] mul_val;
	logic [31:0] min_val;
	logic        mul_ok;
	logic        mul_bad;
	logic signed [63:0] prod_s;
	logic [63:0] prod_u;

	always_comb
	begin
		op_a = issue.first_source_reg;
		op_b = issue.imm_form ? issue.immediate_operand
			: issue.second_source_reg;
		min_val = (op_a < op_b) ? op_a : op_b;
		prod_s = 64'h0000_0000_0000_0000;
		prod_u = 64'h0000_0000_0000_0000;
		mul_val = 32'h0000_0000;
		case (issue.opcode)
			uhmu_pkg::OP_MULH:
			begin
				prod_s = $signed(op_a) * $signed({{16{op_b[31]}}, op_b[31:16]});
				mul_val = prod_s[31:0];
			end
			uhmu_pkg::OP_MULHH:
			begin
				prod_s = $signed({{16{op_a[31]}}, op_a[31:16]})
					* $signed({{16{op_b[31]}}, op_b[31:16]});
				mul_val = prod_s[31:0];
			end
			uhmu_pkg::OP_MULHHS:
			begin
				prod_s = $signed(op_a) * $signed({{16{op_b[31]}}, op_b[31:16]});
				mul_val = prod_s[47:16];
			end
			uhmu_pkg::OP_MULHHU:
			begin
				prod_u = {48'h0, op_a[31:16]} * {48'h0, op_b[31:16]};
				mul_val = prod_u[31:0];
			end
			uhmu_pkg::OP_MULHS:
			begin
				prod_s = $signed(op_a) * $signed({16'h0000, op_b[31:16]});
				mul_val = {prod_s[15:0], 16'h0000};
			end
			uhmu_pkg::OP_MULHU:
			begin
				prod_u = {32'h0, op_a} * {48'h0, op_b[31:16]};
				mul_val = prod_u[31:0];
			end
			default:
			begin
				mul_val = 32'h0000_0000;
			end
		endcase
		mul_bad = issue.valid && is_mul(issue.opcode)
			&& (issue.dest == uhmu_pkg::LINK_REG);
		mul_ok = issue.valid && is_mul(issue.opcode) && !mul_bad;
	end

	////////////////////////////////////////////////////////////////////////
	// Result pipeline.

	uhmu_pkg::uhmu_wb_type alu_d, alu_q;
	uhmu_pkg::uhmu_wb_type st1_d, st1_q;
	uhmu_pkg::uhmu_wb_type st2_d, st2_q;
	logic                  bad_d, bad_q;

	always_comb
	begin
		alu_d.valid = issue.valid && (issue.opcode == uhmu_pkg::OP_MINU);
		alu_d.dest = issue.dest;
		alu_d.data = min_val;
		st1_d.valid = mul_ok;
		st1_d.dest = issue.dest;
		st1_d.data = mul_val;
		st2_d = st1_q;
		bad_d = mul_bad;
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			alu_q <= '{1'b0, uhmu_pkg::DEST_RESET, uhmu_pkg::RESULT_RESET};
			st1_q <= '{1'b0, uhmu_pkg::DEST_RESET, uhmu_pkg::RESULT_RESET};
			st2_q <= '{1'b0, uhmu_pkg::DEST_RESET, uhmu_pkg::RESULT_RESET};
			bad_q <= 1'b0;
		end
		else
		begin
			alu_q <= alu_d;
			st1_q <= st1_d;
			st2_q <= st2_d;
			bad_q <= bad_d;
		end
	end

	assign alu_result = alu_q;
	assign mul_result = st2_q;
	assign illegal_dest = bad_q;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_mul_issue;
		issue.valid && is_mul(issue.opcode) && issue.dest != uhmu_pkg::LINK_REG;
	endsequence

	sequence s_link_issue;
		issue.valid && is_mul(issue.opcode) && issue.dest == uhmu_pkg::LINK_REG;
	endsequence

	sequence s_minu_issue;
		issue.valid && issue.opcode == uhmu_pkg::OP_MINU;
	endsequence

	sequence s_mul_due;
		##2 (mul_result.valid && mul_result.dest == $past(issue.dest, 2));
	endsequence

	sequence s_link_refusal;
		illegal_dest
		##1 !(mul_result.valid && mul_result.dest == uhmu_pkg::LINK_REG);
	endsequence

	a_mul_latency: assert property (@(posedge clock) disable iff (!rstn)
		s_mul_issue |-> s_mul_due)
		else $error("multiply result not valid two cycles after issue");
	a_mul_source: assert property (@(posedge clock) disable iff (!rstn)
		mul_result.valid |-> $past(issue.valid, 2)
		&& $past(is_mul(issue.opcode), 2)
		&& $past(issue.dest, 2) != uhmu_pkg::LINK_REG)
		else $error("multiply result without a matching issue");

	a_link_refused: assert property (@(posedge clock) disable iff (!rstn)
		s_link_issue |-> ##1 s_link_refusal)
		else $error("link register destination not refused");
	a_flag_source: assert property (@(posedge clock) disable iff (!rstn)
		illegal_dest |-> $past(issue.valid) && $past(is_mul(issue.opcode))
		&& $past(issue.dest) == uhmu_pkg::LINK_REG)
		else $error("refusal flag without a link destination");

	a_alu_source: assert property (@(posedge clock) disable iff (!rstn)
		alu_result.valid |-> $past(issue.valid)
		&& $past(issue.opcode) == uhmu_pkg::OP_MINU)
		else $error("minimum result without a matching issue");
	a_minu_value: assert property (@(posedge clock) disable iff (!rstn)
		s_minu_issue |=> alu_result.valid
		&& alu_result.dest == $past(issue.dest)
		&& alu_result.data <= $past(op_a) && alu_result.data <= $past(op_b)
		&& (alu_result.data == $past(op_a) || alu_result.data == $past(op_b)))
		else $error("unsigned minimum wrong");
	a_imm_minu: assert property (@(posedge clock) disable iff (!rstn)
		s_minu_issue ##0 issue.imm_form |=> alu_result.data
		<= $past(issue.immediate_operand)
		&& alu_result.data <= $past(issue.first_source_reg))
		else $error("immediate form did not replace source two");
	a_reg_minu: assert property (@(posedge clock) disable iff (!rstn)
		s_minu_issue ##0 !issue.imm_form |=> alu_result.data
		<= $past(issue.second_source_reg)
		&& alu_result.data <= $past(issue.first_source_reg))
		else $error("register form did not use source two");

	a_mulh_value: assert property (@(posedge clock) disable iff (!rstn)
		s_mul_issue ##0 (issue.opcode == uhmu_pkg::OP_MULH) |-> ##2
		mul_result.data == 32'($past(signed'(op_a), 2)
		* $past(signed'(op_b) >>> 16, 2)))
		else $error("signed word by upper half wrong");
	a_mulhh_value: assert property (@(posedge clock) disable iff (!rstn)
		s_mul_issue ##0 (issue.opcode == uhmu_pkg::OP_MULHH) |-> ##2
		mul_result.data == 32'($past(signed'(op_a) >>> 16, 2)
		* $past(signed'(op_b) >>> 16, 2)))
		else $error("signed upper by upper wrong");
	a_mulhhs_value: assert property (@(posedge clock) disable iff (!rstn)
		s_mul_issue ##0 (issue.opcode == uhmu_pkg::OP_MULHHS) |-> ##2
		mul_result.data == 32'(($past(longint'(signed'(op_a)), 2)
		* $past(longint'(signed'(op_b) >>> 16), 2)) >>> 16))
		else $error("scaled multiply wrong");
	a_mulhhu_value: assert property (@(posedge clock) disable iff (!rstn)
		s_mul_issue ##0 (issue.opcode == uhmu_pkg::OP_MULHHU) |-> ##2
		mul_result.data == $past(op_a[31:16], 2) * $past(op_b[31:16], 2))
		else $error("unsigned upper by upper wrong");
	a_mulhs_low: assert property (@(posedge clock) disable iff (!rstn)
		s_mul_issue ##0 (issue.opcode == uhmu_pkg::OP_MULHS) |-> ##2
		mul_result.data == {16'($past(op_a, 2) * $past(op_b[31:16], 2)),
		16'h0000})
		else $error("shifted multiply wrong");
	a_mulhu_value: assert property (@(posedge clock) disable iff (!rstn)
		s_mul_issue ##0 (issue.opcode == uhmu_pkg::OP_MULHU) |-> ##2
		mul_result.data == 32'($past(op_a, 2) * $past(op_b[31:16], 2)))
		else $error("unsigned word by upper half wrong");

endmodule
`default_nettype wire

// *** testbench/uhmu_issuer.sv ***
// Issue-side partner model that presents operations to the unit.
`default_nettype none
module uhmu_issuer
(
	// Clock.
	input  wire logic                     clock,
	// Request from the bench and issue to the unit.
	input  wire uhmu_pkg::uhmu_issue_type req,
	output uhmu_pkg::uhmu_issue_type      issue
);
	timeunit 1ns;
	timeprecision 1ns;
	uhmu_pkg::uhmu_issue_type idle_q;
	// Idle slots carry the last request's fields and their inverse in turn, with valid cleared.
	always @(posedge clock)
	begin
		idle_q <= req.valid ? req : ~idle_q;
	end
	// A link destination leaves whenever the bench asks for one, for any opcode, refused or not.
	// Results are read no sooner than their due bundle.
	assign issue = req.valid ? req : {1'b0, idle_q[107:0]};
endmodule
`default_nettype wire

// *** testbench/upper_half_multiply_unit_test.sv ***
// Self-checking bench for the upper-half multiply unit.
`default_nettype none
module upper_half_multiply_unit_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic                     clock = 1'b0;
	logic                     rstn = 1'b0;
	logic                     illegal_dest;
	logic                     ex_ill[int];
	logic [31:0]              rnd = 32'h0000_0046;
	logic [4:0]               ops[8] = '{5'h13, 5'h17, 5'h1D, 5'h14,
		5'h1E, 5'h1F, 5'h18, 5'h00};
	int                       cyc = 0;
	int                       miscompares = 0;
	int                       n_compared = 0;
	uhmu_pkg::uhmu_issue_type req = '0;
	uhmu_pkg::uhmu_issue_type issue;
	uhmu_pkg::uhmu_wb_type    alu_result, mul_result, ex_alu[int], ex_mul[int];
	uhmu_issuer partner (.clock(clock), .req(req), .issue(issue));
	uhmu_unit DUT (.clock(clock), .rstn(rstn), .issue(issue),
		.alu_result(alu_result), .mul_result(mul_result),
		.illegal_dest(illegal_dest));
	always #20 clock = ~clock;
	always @(posedge clock) cyc++;
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
	endfunction
	function automatic logic [31:0] model(logic [4:0] op, logic [31:0] a, b);
		longint sa = int'(a), ua = a, sh = int'(b) >>> 16, uh = b[31:16];
		case (op)
			5'h13: return (a < b) ? a : b;
			5'h17: return 32'(sa * sh);
			5'h1D: return 32'((int'(a) >>> 16) * sh);
			5'h14: return 32'((sa * sh) >>> 16);
			5'h1E: return 32'(uh * a[31:16]);
			5'h1F: return 32'((sa * uh) << 16);
			default: return 32'(ua * uh);
		endcase
	endfunction
	task automatic check(string name, logic [37:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic send(logic [4:0] op, logic m, logic [5:0] d,
		logic [31:0] a, b, c);
		uhmu_pkg::uhmu_wb_type w;
		req = '{1'b1, op, m, d, a, b, c};
		w = '{1'b1, d, model(op, a, m ? c : b)};
		if (op == uhmu_pkg::OP_MINU)
			ex_alu[cyc + 1] = w;
		else if (op != 5'h00 && d == uhmu_pkg::LINK_REG)
			ex_ill[cyc + 1] = 1'b1;
		else if (op != 5'h00)
			ex_mul[cyc + uhmu_pkg::MUL_LATENCY] = w;
	endtask
	// Valid flags and the refusal flag are compared against the model at every cycle, result words only when a result is due.
	always @(negedge clock)
	begin
		uhmu_pkg::uhmu_wb_type ea, em;
		ea = ex_alu.exists(cyc) ? ex_alu[cyc] : '0;
		em = ex_mul.exists(cyc) ? ex_mul[cyc] : '0;
		check("alu_valid", 38'(alu_result.valid), 38'(ea.valid));
		if (ea.valid) check("alu_word", alu_result[37:0], ea[37:0]);
		check("mul_valid", 38'(mul_result.valid), 38'(em.valid));
		if (em.valid) check("mul_word", mul_result[37:0], em[37:0]);
		check("illegal", 38'(illegal_dest), 38'(ex_ill.exists(cyc)));
	end
	initial
	begin
		logic [31:0] a, b, c, k;
		repeat (4) @(posedge clock);
		#1 rstn = 1'b1;
		repeat (600)
		begin
			@(posedge clock);
			#1;
			a = lfsr(rnd);
			b = lfsr(a);
			c = lfsr(b);
			k = lfsr(c);
			rnd = k;
			if (!k[9]) a = k[8] ? 32'hFFFF_FFFF : 32'h8000_0000;
			if (!k[11]) b = k[10] ? 32'hFFFF_FFFF : 32'h8000_0000;
			if (k[7:6] == 2'h0) req.valid = 1'b0;
			else send(ops[k[2:0]], k[3], (k[5:4] == 2'h0) ?
				uhmu_pkg::LINK_REG : k[21:16], a, b, k[12] ? c : b);
		end
		@(posedge clock);
		#1 req.valid = 1'b0;
		repeat (4) @(posedge clock);
		close_out();
	end
	initial
	begin
		#(700 * 40);
		miscompares++;
		close_out();
	end
endmodule
`default_nettype wire
